// >>> logic/pcg_clock_gen.v
/*
 clock generation and start-up control: halved/full core clock enables,
 converter clock, low power ticks, start-up and wake sequencing, and an
 ahb-lite register slave.
 assumes i_clk is the pll output rate and oscillators arrive as levels.
*/
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_regs.vh"

//Contract
//(RL1) pll multiplies slow oscillator by fixed factor
//(RL2) halved clock until lock, then full
//(RL3) converter clock is pll/28 or slow osc
//(RL4) converter select bit picks its source
//(RL5) status register shows read-only lock bit
//(RL6) lock-change interrupt gated by enable bit
//(RL7) flag sets on lock edge, write-one clears
//(RL8) two slow cycles before pll restart
//(RL9) wake takes 2 slow plus 6 core
//(RL10) cpu runs before lock on halved clock
//(RL11) reset adds 14 core plus fuse count
//(RL12) fuse 00 reserved; 11 is default
//(RL13) reset real-time part counted on low-power osc
//(RL14) factory trim loaded into trim register at reset
//(RL15) watchdog and wake timer run on low-power osc
//(RL16) clock out is core clock/2, stops asleep
//(RL17) sleep halts unused clocks, core stops
//(RL18) wake input detected without peripheral clock
//(RL19) nvm clock gated with core clock
//(RL20) half-to-full switch is glitch-free
module pcg_clock_gen #(
	parameter [13:0] DLY_2K = `PCG_DLY_2K,
	parameter [13:0] DLY_4K = `PCG_DLY_4K,
	parameter [13:0] DLY_8K = `PCG_DLY_8K
) (
	input wire i_clk,
	input wire i_rstn,
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire i_hready,
	input wire [31:0] i_hwdata,
	output wire [31:0] o_hrdata,
	output wire o_hreadyout,
	output wire o_hresp,
	input wire i_pll_lock,
	input wire i_slow_osc,
	input wire i_ultra_low_power_osc,
	input wire i_wake,
	input wire i_sleep_req,
	input wire [1:0] i_sleep_mode,
	input wire i_irq_ack,
	input wire [1:0] i_startup_delay_fuse,
	input wire [7:0] i_factory_trim,
	output wire o_pll_enable,
	output wire [6:0] o_pll_mult,
	output wire o_core_clock_en,
	output wire o_peripheral_clock_en,
	output wire o_nvm_clock_en,
	output wire o_converter_clock_en,
	output wire o_wdt_clock_en,
	output wire o_wut_clock_en,
	output wire o_cpu_run,
	output wire o_lock_irq,
	output wire [7:0] o_slow_osc_trim,
	output wire o_clock_out_pin
);

	localparam [2:0] S_RST_SYS = 3'h0;
	localparam [2:0] S_RST_LPO = 3'h1;
	localparam [2:0] S_RUN = 3'h2;
	localparam [2:0] S_SLEEP = 3'h3;
	localparam [2:0] S_WAKE_RC = 3'h4;
	localparam [2:0] S_WAKE_SYS = 3'h5;
	localparam [1:0] M_IDLE = 2'h1;

	// register index decode, shared by reads and writes
	function [1:0] reg_sel;
		input [`PCG_ADDR_W-1:0] a;
		begin
			case (a[`PCG_ADDR_W-1:2])
				{2'h0, `PCG_IDX_CSR}: reg_sel = 2'h0;
				{2'h0, `PCG_IDX_MCU}: reg_sel = 2'h1;
				{2'h0, `PCG_IDX_TRIM}: reg_sel = 2'h2;
				default: reg_sel = 2'h3;
			endcase
		end
	endfunction

	function is_conv;
		input [`PCG_ADDR_W-1:0] a;
		begin
			is_conv = (a[`PCG_ADDR_W-1:2] == {2'h0, `PCG_IDX_CONV});
		end
	endfunction

	// low-power count chosen by the start-up fuse; 00 falls back to the default
	function [13:0] lpo_len;
		input [1:0] f;
		begin
			case (f)
				2'h1: lpo_len = DLY_2K;
				2'h2: lpo_len = DLY_4K;
				default: lpo_len = DLY_8K;
			endcase
		end
	endfunction

	wire [5:0] sy_lvl;
	wire [5:0] sy_rise;
	wire [5:0] sy_edge;

	// asynchronous pins, including the wake line, pass two flops
	pcg_sync #(.W(6)) u_sync (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_async({i_startup_delay_fuse, i_wake, i_ultra_low_power_osc, i_slow_osc, i_pll_lock}),
		.o_level(sy_lvl),
		.o_rise(sy_rise),
		.o_edge(sy_edge)
	); // RL18

	wire lock_s = sy_lvl[0];
	wire lock_edge = sy_edge[0];
	wire slow_tick = sy_rise[1];
	wire lpo_tick = sy_rise[2];
	wire wake_rise = sy_rise[3];
	wire [1:0] fuse_s = sy_lvl[5:4];

	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [13:0] cnt_ff;
	reg [13:0] nxt_cnt;
	reg pll_en_ff;
	reg nxt_pll_en;
	reg [1:0] mode_ff;
	reg [1:0] nxt_mode;
	reg [1:0] fuse_ff;
	reg phase_ff;
	reg full_ff;
	reg [4:0] div_ff;
	reg core_en_ff;
	reg per_en_ff;
	reg conv_en_ff;
	reg lpo_en_ff;
	reg run_ff;
	reg clk_out_ff;
	reg irq_ff;
	reg [6:0] mult_ff;

	reg swen_ff;
	reg flag_ff;
	reg ie_ff;
	reg clk_out_en_ff;
	reg conv_sel_ff;
	reg [7:0] trim_ff;

	reg pend_ff;
	reg wr_ff;
	reg [`PCG_ADDR_W-1:0] addr_ff;
	reg rdy_ff;
	reg [31:0] rdata_ff;

	wire pll_tick = pll_en_ff & (full_ff | phase_ff); // RL2 RL10
	wire awake = (state_ff != S_SLEEP);
	wire acc = i_hsel & i_htrans[1] & i_hready;
	wire wr_now = pend_ff & wr_ff;
	wire [1:0] wsel = reg_sel(addr_ff);
	wire csr_wr = wr_now & (wsel == 2'h0);
	wire deep = (i_sleep_mode != M_IDLE);

	// start-up and wake sequencer
	always @* begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_pll_en = pll_en_ff;
		nxt_mode = mode_ff;
		case (state_ff)
			S_RST_SYS: begin
				if (pll_tick) begin
					nxt_cnt = cnt_ff + 14'h0001;
					if (cnt_ff == `PCG_RST_SYS - 14'h0001) begin // RL11
						nxt_state = S_RST_LPO;
						nxt_cnt = 14'h0000;
					end
				end
			end
			S_RST_LPO: begin
				if (lpo_tick) begin // RL13
					nxt_cnt = cnt_ff + 14'h0001;
					if (cnt_ff == lpo_len(fuse_ff) - 14'h0001) begin // RL11 RL12
						nxt_state = S_RUN;
						nxt_cnt = 14'h0000;
					end
				end
			end
			S_RUN: begin
				if (i_sleep_req && (i_sleep_mode != 2'h0)) begin // RL17
					nxt_state = S_SLEEP;
					nxt_mode = i_sleep_mode;
					if (deep && !swen_ff)
						nxt_pll_en = 1'b0;
				end
			end
			S_SLEEP: begin
				nxt_cnt = 14'h0000;
				if (wake_rise) begin
					if (mode_ff == M_IDLE)
						nxt_state = S_RUN;
					else if (pll_en_ff)
						nxt_state = S_WAKE_SYS; // RL8
					else
						nxt_state = S_WAKE_RC;
				end
			end
			S_WAKE_RC: begin
				if (slow_tick) begin
					nxt_cnt = cnt_ff + 14'h0001;
					if (cnt_ff == `PCG_WAKE_RC - 14'h0001) begin // RL8 RL9
						nxt_state = S_WAKE_SYS;
						nxt_pll_en = 1'b1;
						nxt_cnt = 14'h0000;
					end
				end
			end
			S_WAKE_SYS: begin
				if (pll_tick) begin
					nxt_cnt = cnt_ff + 14'h0001;
					if (cnt_ff == `PCG_WAKE_SYS - 14'h0001) begin // RL9
						nxt_state = S_RUN;
						nxt_cnt = 14'h0000;
					end
				end
			end
			default: begin
				nxt_state = S_RST_SYS;
				nxt_cnt = 14'h0000;
			end
		endcase
	end

	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_ff <= S_RST_SYS;
			cnt_ff <= 14'h0000;
			pll_en_ff <= 1'b1;
			mode_ff <= 2'h0;
			fuse_ff <= 2'h3;
			mult_ff <= 7'h00;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			pll_en_ff <= nxt_pll_en;
			mode_ff <= nxt_mode;
			mult_ff <= `PCG_PLL_MULT; // RL1
			if (state_ff == S_RST_SYS)
				fuse_ff <= fuse_s;
		end
	end

	// clock enables; mode only changes right after a pulse
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			phase_ff <= 1'b0;
			full_ff <= 1'b0;
			div_ff <= 5'h00;
			core_en_ff <= 1'b0;
			per_en_ff <= 1'b0;
			conv_en_ff <= 1'b0;
			lpo_en_ff <= 1'b0;
			run_ff <= 1'b0;
			clk_out_ff <= 1'b0;
		end else begin
			phase_ff <= ~phase_ff;
			if (phase_ff)
				full_ff <= lock_s & pll_en_ff; // RL20
			core_en_ff <= pll_tick & awake; // RL17 RL19
			per_en_ff <= pll_tick & (awake | (mode_ff == M_IDLE)); // RL17
			if (div_ff == `PCG_CONV_DIV - 5'h01)
				div_ff <= 5'h00;
			else
				div_ff <= div_ff + 5'h01;
			if (conv_sel_ff) // RL4
				conv_en_ff <= slow_tick; // RL3
			else
				conv_en_ff <= pll_en_ff & (div_ff == 5'h00); // RL3
			lpo_en_ff <= lpo_tick; // RL15
			run_ff <= (nxt_state == S_RUN); // RL10
			if (!clk_out_en_ff || state_ff != S_RUN)
				clk_out_ff <= 1'b0; // RL16
			else if (pll_tick)
				clk_out_ff <= ~clk_out_ff; // RL16
		end
	end

	// ahb-lite slave: one wait state, data phase registered
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pend_ff <= 1'b0;
			wr_ff <= 1'b0;
			addr_ff <= {`PCG_ADDR_W{1'b0}};
			rdy_ff <= 1'b1;
			rdata_ff <= 32'h0000_0000;
		end else if (acc) begin
			pend_ff <= 1'b1;
			wr_ff <= i_hwrite;
			addr_ff <= i_haddr[`PCG_ADDR_W-1:0];
			rdy_ff <= 1'b0;
		end else if (pend_ff) begin
			pend_ff <= 1'b0;
			rdy_ff <= 1'b1;
			rdata_ff <= 32'h0000_0000;
			if (!wr_ff) begin
				case (wsel)
					2'h0: begin
						rdata_ff[`PCG_CSR_SWEN] <= swen_ff;
						rdata_ff[`PCG_CSR_LOCK] <= lock_s; // RL5
						rdata_ff[`PCG_CSR_FLAG] <= flag_ff;
						rdata_ff[`PCG_CSR_IE] <= ie_ff;
					end
					2'h1: rdata_ff[`PCG_MCU_OUT_EN] <= clk_out_en_ff;
					2'h2: rdata_ff[7:0] <= trim_ff;
					default: rdata_ff[`PCG_CONV_SEL] <= is_conv(addr_ff) & conv_sel_ff;
				endcase
			end
		end
	end

	// register file; the lock bit has no storage and ignores writes
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			swen_ff <= 1'b0;
			ie_ff <= 1'b0;
			clk_out_en_ff <= 1'b0;
			conv_sel_ff <= 1'b0;
			trim_ff <= `PCG_TRIM_RST;
		end else begin
			if (csr_wr) begin
				swen_ff <= i_hwdata[`PCG_CSR_SWEN];
				ie_ff <= i_hwdata[`PCG_CSR_IE]; // RL6
			end
			if (wr_now && wsel == 2'h1)
				clk_out_en_ff <= i_hwdata[`PCG_MCU_OUT_EN]; // RL16
			if (wr_now && wsel == 2'h3 && is_conv(addr_ff))
				conv_sel_ff <= i_hwdata[`PCG_CONV_SEL]; // RL4
			if (state_ff == S_RST_SYS)
				trim_ff <= i_factory_trim; // RL14
			else if (wr_now && wsel == 2'h2)
				trim_ff <= i_hwdata[7:0];
		end
	end

	// lock-change flag: an edge in the clearing cycle still sets it
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			flag_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			if (lock_edge)
				flag_ff <= 1'b1; // RL7
			else if ((csr_wr && i_hwdata[`PCG_CSR_FLAG]) || i_irq_ack)
				flag_ff <= 1'b0; // RL7
			irq_ff <= (flag_ff | lock_edge) & ie_ff; // RL6
		end
	end

	assign o_hrdata = rdata_ff;
	assign o_hreadyout = rdy_ff;
	assign o_hresp = 1'b0;
	assign o_pll_enable = pll_en_ff;
	assign o_pll_mult = mult_ff;
	assign o_core_clock_en = core_en_ff;
	assign o_peripheral_clock_en = per_en_ff;
	assign o_nvm_clock_en = core_en_ff; // RL19
	assign o_converter_clock_en = conv_en_ff;
	assign o_wdt_clock_en = lpo_en_ff;
	assign o_wut_clock_en = lpo_en_ff;
	assign o_cpu_run = run_ff;
	assign o_lock_irq = irq_ff;
	assign o_slow_osc_trim = trim_ff;
	assign o_clock_out_pin = clk_out_ff;

endmodule // pcg_clock_gen

`default_nettype wire

// >>> logic/pcg_regs.vh
/*
 constants of the clock generation and start-up block: register indexes,
 field positions, reset values and cycle counts.
 assumes inclusion by bare name from the design files.
*/
`ifndef PCG_REGS_VH
`define PCG_REGS_VH

// register indexes; byte address is four times the index
`define PCG_IDX_CSR 8'hd8
`define PCG_IDX_MCU 8'h55
`define PCG_IDX_TRIM 8'h67
`define PCG_IDX_CONV 8'h7c
`define PCG_ADDR_W 12

// pll_ctrl_status_reg fields
`define PCG_CSR_SWEN 5
`define PCG_CSR_LOCK 4
`define PCG_CSR_FLAG 1
`define PCG_CSR_IE 0
// mcu control field
`define PCG_MCU_OUT_EN 5
// converter_control_a field
`define PCG_CONV_SEL 0

`define PCG_TRIM_RST 8'h00
`define PCG_PLL_MULT 7'h70
`define PCG_CONV_DIV 5'h1c
`define PCG_RST_SYS 14'h000e
`define PCG_WAKE_SYS 14'h0006
`define PCG_WAKE_RC 14'h0002
`define PCG_DLY_2K 14'h0800
`define PCG_DLY_4K 14'h1000
`define PCG_DLY_8K 14'h2000

`endif

// >>> logic/pcg_sync.v
/*
 two-stage synchroniser with edge detection, one lane per bit.
 assumes asynchronous inputs and one system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pcg_sync #(
	parameter W = 4
) (
	input wire i_clk,
	input wire i_rstn,
	input wire [W-1:0] i_async,
	output wire [W-1:0] o_level,
	output wire [W-1:0] o_rise,
	output wire [W-1:0] o_edge
);

	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : lane
			reg s1_ff;
			reg s2_ff;
			reg s3_ff;
			always @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					s3_ff <= 1'b0;
				end else begin
					s1_ff <= i_async[g];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
				end
			end
			assign o_level[g] = s2_ff;
			assign o_rise[g] = s2_ff & ~s3_ff;
			assign o_edge[g] = s2_ff ^ s3_ff;
		end
	endgenerate

endmodule // pcg_sync

`default_nettype wire

// >>> tb/pcg_clock_gen_props.sv
/* port checker for pcg_clock_gen.
 assumes one clock and the active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module pcg_chk #(
	parameter [13:0] DLY_2K = 14'h0800,
	parameter [13:0] DLY_4K = 14'h1000,
	parameter [13:0] DLY_8K = 14'h2000
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_pll_lock,
	input wire logic i_sleep_req,
	input wire logic [1:0] i_sleep_mode,
	input wire logic [1:0] i_startup_delay_fuse,
	input wire logic [6:0] o_pll_mult,
	input wire logic o_core_clock_en,
	input wire logic o_nvm_clock_en,
	input wire logic o_wdt_clock_en,
	input wire logic o_wut_clock_en,
	input wire logic o_cpu_run,
	input wire logic o_clock_out_pin
);
	logic [15:0] wd_n;
	logic ran;
	wire [13:0] need = i_startup_delay_fuse == 2'h1 ? DLY_2K :
		i_startup_delay_fuse == 2'h2 ? DLY_4K : DLY_8K;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wd_n <= 16'h0000;
			ran <= 1'b0;
		end else begin
			wd_n <= wd_n + {15'h0000, o_wdt_clock_en & ~ran};
			ran <= ran | o_cpu_run;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_slow;
		(!i_pll_lock)[*8] ##0 o_core_clock_en;
	endsequence
	sequence s_fast;
		i_pll_lock[*8] ##0 o_core_clock_en ##1 o_cpu_run;
	endsequence
	chk_fixed_mult: assert property ($past(i_rstn) |-> o_pll_mult == 7'h70)
		else $error("pll multiplier wrong");
	chk_half_rate: assert property (s_slow |=> !o_core_clock_en)
		else $error("core pulses too close while unlocked");
	chk_full_rate: assert property (s_fast |-> o_core_clock_en)
		else $error("core pulse missing while locked");
	chk_nvm_core: assert property (o_nvm_clock_en == o_core_clock_en)
		else $error("nvm clock differs from core clock");
	chk_wdt_wut: assert property (o_wdt_clock_en == o_wut_clock_en)
		else $error("watchdog and wake timer ticks differ");
	chk_sleep_halt: assert property (o_cpu_run && i_sleep_req && i_sleep_mode != 2'h0
		|=> !o_cpu_run ##1 !o_core_clock_en) else $error("core clock runs in sleep");
	chk_clkout_sleep: assert property (!o_cpu_run && !$past(o_cpu_run)
		|-> !o_clock_out_pin) else $error("clock out runs outside run");
	chk_clkout_rise: assert property ($rose(o_clock_out_pin)
		|-> o_core_clock_en && $past(o_cpu_run)) else $error("clock out rise without pulse");
	chk_reset_wait: assert property ($rose(o_cpu_run) && !ran |-> wd_n >= {2'h0, need})
		else $error("start-up shorter than fuse count");
endmodule // pcg_chk
bind pcg_clock_gen pcg_chk #(.DLY_2K(DLY_2K), .DLY_4K(DLY_4K), .DLY_8K(DLY_8K)) u_chk (
	.i_clk, .i_rstn, .i_pll_lock, .i_sleep_req, .i_sleep_mode, .i_startup_delay_fuse,
	.o_pll_mult, .o_core_clock_en, .o_nvm_clock_en, .o_wdt_clock_en, .o_wut_clock_en,
	.o_cpu_run, .o_clock_out_pin);
`default_nettype wire

// >>> tb/pcg_clock_gen_tb.sv
/* self-checking bench for pcg_clock_gen.
 assumes pcg_regs.vh on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "pcg_regs.vh"
module pcg_clock_gen_tb;
	localparam int SP = 40;
	localparam int CSR = `PCG_IDX_CSR * 4;
	localparam int MCU = `PCG_IDX_MCU * 4;
	localparam int TRIM = `PCG_IDX_TRIM * 4;
	localparam int CONV = `PCG_IDX_CONV * 4;
	logic i_clk = 0, i_rstn = 0, i_hsel = 0, i_hwrite = 0, i_wake = 0;
	logic i_sleep_req = 0, i_irq_ack = 0, lk = 0, fl = 0, pd = 0;
	logic [1:0] i_htrans = 0, i_sleep_mode = 0, i_startup_delay_fuse;
	logic [2:0] i_hsize = 3'h2;
	logic [7:0] i_factory_trim, o_slow_osc_trim;
	logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, rd;
	logic [6:0] o_pll_mult;
	logic i_pll_lock, i_slow_osc, i_ultra_low_power_osc, o_hreadyout, o_hresp;
	logic o_pll_enable, o_core_clock_en, o_peripheral_clock_en, o_nvm_clock_en;
	logic o_converter_clock_en, o_wdt_clock_en, o_wut_clock_en, o_cpu_run;
	logic o_lock_irq, o_clock_out_pin;
	wire i_hready = o_hreadyout;
	int err_total = 0, checks = 0, cyc = 0, nc, nv, nt, np, n;
	int seed = 32'ha789;
	int sh[int];
	pcg_clock_gen #(.DLY_2K(4), .DLY_4K(6), .DLY_8K(8)) DUT (.*);
	pcg_far_model #(.SP(SP)) far (.i_clk(i_clk), .i_pll_en(o_pll_enable), .i_lock_req(lk),
		.o_slow_osc(i_slow_osc), .o_wd_osc(i_ultra_low_power_osc), .o_lock(i_pll_lock));
	initial forever #10 i_clk = ~i_clk;
	task automatic end_sim;
		if (err_total == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		nc += int'(o_core_clock_en);
		nv += int'(o_converter_clock_en);
		np += int'(o_peripheral_clock_en);
		nt += int'(o_clock_out_pin & ~pd);
		pd <= o_clock_out_pin;
		if (cyc > 60000) begin
			err_total++;
			end_sim();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic bus(input logic w, input int a, input logic [31:0] d);
		@(posedge i_clk);
		i_hsel <= 1;
		i_htrans <= 2'b10;
		i_haddr <= a;
		i_hwrite <= w;
		do @(posedge i_clk); while (i_hready !== 1);
		i_hsel <= 0;
		i_htrans <= 0;
		i_hwdata <= d;
		do @(posedge i_clk); while (i_hready !== 1);
		rd = o_hrdata;
		if (w) sh[a] = d;
		if (w && a == CSR && d[1]) fl = 0;
	endtask
	task automatic rchk(input int a);
		int m;
		m = a == CSR ? 'h21 : a == MCU ? 'h20 : a == TRIM ? 'hff : a == CONV ? 1 : 0;
		bus(0, a, 0);
		chk("read", (sh[a] & m) | (a == CSR ? {i_pll_lock, 2'b00, fl, 1'b0} : 0), rd);
		chk("hresp", 0, o_hresp);
	endtask
	task automatic run(input int k);
		@(negedge i_clk);
		{nc, nv, nt, np} = 0;
		repeat (k) @(negedge i_clk);
	endtask
	initial begin
		i_factory_trim = $random(seed);
		i_startup_delay_fuse = $random(seed);
		sh[CSR] = 0;
		sh[MCU] = 0;
		sh[CONV] = 0;
		sh[4] = 0;
		sh[TRIM] = i_factory_trim;
		repeat (12) @(posedge i_clk);
		chk("pll_en", 1, o_pll_enable);
		i_rstn <= 1;
		n = i_startup_delay_fuse == 1 ? 4 : i_startup_delay_fuse == 2 ? 6 : 8;
		wait (o_cpu_run === 1);
		@(posedge i_clk);
		chk("startup", 1, cyc - 12 > 28 + 6 * (n - 1));
		chk("trim_rst", i_factory_trim, o_slow_osc_trim);
		foreach (sh[a]) rchk(a);
		bus(1, TRIM, 32'h005a);
		chk("trim_out", 32'h005a, o_slow_osc_trim);
		bus(1, CSR, 32'h00ff);
		bus(1, 4, 32'h00ff);
		foreach (sh[a]) rchk(a);
		bus(1, CSR, 1);
		lk <= 1;
		fl = 1;
		repeat (210) @(posedge i_clk);
		chk("irq", 1, o_lock_irq);
		rchk(CSR);
		bus(1, CSR, 3);
		rchk(CSR);
		bus(1, MCU, 32'h0020);
		run(100);
		chk("full", 100, nc);
		chk("clkout", 1, nt inside {[49:51]});
		lk <= 0;
		fl = 1;
		repeat (8) @(posedge i_clk);
		chk("irq", 1, o_lock_irq);
		i_irq_ack <= 1;
		@(posedge i_clk);
		i_irq_ack <= 0;
		fl = 0;
		run(100);
		chk("half", 1, nc inside {[49:51]});
		chk("ack", 0, o_lock_irq);
		rchk(CSR);
		bus(1, CSR, 0);
		lk <= 1;
		fl = 1;
		run(220);
		chk("masked", 0, o_lock_irq);
		rchk(CSR);
		bus(1, CSR, 2);
		for (int s = 0; s < 2; s++) begin
			bus(1, CONV, s);
			run(s ? 10 * SP : 280);
			chk("conv", 1, nv inside {[9:11]});
		end
		for (int md = 1; md < 5; md++) begin
			if (md == 4) bus(1, CSR, 32'h0020);
			@(posedge i_clk);
			i_sleep_mode <= (md == 4) ? 2'h2 : 2'(md);
			i_sleep_req <= 1;
			@(posedge i_clk);
			i_sleep_req <= 0;
			@(posedge i_clk);
			run(60);
			chk("sleep", 0, nc);
			chk("idle_io", md == 1, np > 50);
			chk("clkout_off", 0, nt);
			chk("pll_off", md == 1 || md == 4, o_pll_enable);
			@(posedge i_clk);
			i_wake <= 1;
			n = cyc;
			wait (o_cpu_run === 1);
			@(posedge i_clk);
			i_wake <= 0;
			chk("wake", 1, md == 1 ? cyc - n < 10 : md == 4 ? cyc - n < SP : cyc - n > SP + 6);
			chk("prelock", md == 1, i_pll_lock);
		end
		end_sim();
	end
endmodule // pcg_clock_gen_tb
`default_nettype wire

// >>> tb/pcg_far_model.sv
/* far side stand-in: slow and low-power oscillators and pll lock.
 assumes one bench clock; periods are in bench cycles. */
`timescale 1ns/1ps
`default_nettype none
module pcg_far_model #(
	parameter int SP = 40,
	parameter int UP = 6,
	parameter int LK = 200
) (
	input wire logic i_clk,
	input wire logic i_pll_en,
	input wire logic i_lock_req,
	output logic o_slow_osc,
	output logic o_wd_osc,
	output logic o_lock
);
	int sc = 0;
	int uc = 0;
	int lc = 0;
	always @(posedge i_clk) begin
		sc <= (sc + 1) % SP;
		uc <= (uc + 1) % UP;
		lc <= (i_pll_en && i_lock_req) ? ((lc < LK) ? lc + 1 : lc) : 0;
	end
	assign o_slow_osc = sc < SP / 2;
	assign o_wd_osc = uc < UP / 2;
	assign o_lock = lc == LK;
endmodule // pcg_far_model
`default_nettype wire
